// ### rtl/sfot_seq.sv
/*
 Internal operation sequencer of a serial flash: busy timing for erase,
 program and status write, write-enable latch housekeeping, and recovery
 delays after suspend and deep power-down exit.
 Assumes a command decoder on core_clk_in gives single-cycle strobes.
*/
// Behaviour
// - small sector erase busy, typ 10ms, max 130ms
// - sector erase busy, typ 15ms, max 180ms
// - chip erase busy, typ 120ms, max 1500ms
// - ready within 40us after suspend
// - standby within 40us after powerdown exit
// - status write end clears write-enable latch
// - any erase end clears write-enable latch
// - page program end clears write-enable latch
// - status write busy, typ 5ms, max 8ms
`timescale 1ns/100ps
`include "sfot_defines.svh"

module sfot_seq
   import sfot_pkg::*;
#(
   parameter int CNT_W = `SFOT_CNT_W,
   parameter int SMALL_SECTOR_ERASE_DURATION = `SFOT_SSE_CYC,
   parameter int SECTOR_ERASE_DURATION = `SFOT_SE_CYC,
   parameter int WHOLE_ARRAY_ERASE_DURATION = `SFOT_CHE_CYC,
   parameter int STATUS_WRITE_DURATION = `SFOT_WRSR_CYC,
   parameter int PAGE_PROGRAM_DURATION = `SFOT_PP_CYC,
   parameter int SUSPEND_RECOVERY_DELAY = `SFOT_RSUS_CYC,
   parameter int POWERDOWN_EXIT_DELAY = `SFOT_RDP_CYC
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // command strobes
   input wire logic wren_cmd_in,
   input wire logic wrdi_cmd_in,
   input wire logic op_start_in,
   input wire sfot_pkg::sfot_op_type op_code_in,
   input wire logic suspend_cmd_in,
   input wire logic pd_enter_in,
   input wire logic pd_exit_in,
   // status
   output logic busy_out,
   output logic wel_out,
   output logic ready_out,
   output logic powered_down_out,
   output logic op_done_out,
   output logic rejected_out
);
   import sfot_pkg::*;

   // ==========================================================
   // state
   // ==========================================================
   typedef enum logic [2:0] {
      SFOT_IDLE,
      SFOT_BUSY,
      SFOT_SUSP_REC,
      SFOT_SUSPENDED,
      SFOT_DPD,
      SFOT_DPD_REC
   } sfot_state_type;

   sfot_state_type state_r, state_nxt;
   logic wel_r, wel_nxt;
   logic busy_r, busy_nxt;
   logic ready_r, ready_nxt;
   logic pd_r, pd_nxt;
   logic done_r, done_nxt;
   logic rej_r, rej_nxt;
   logic load;
   logic abort;
   logic [CNT_W-1:0] len;
   logic tmr_run;
   logic tmr_done;

   initial begin
      if (WHOLE_ARRAY_ERASE_DURATION >= (64'd1 << CNT_W)) $error("counter too narrow");
      if (SUSPEND_RECOVERY_DELAY < 1 || POWERDOWN_EXIT_DELAY < 1) $error("delay below one");
   end

   // cycle count for an operation
   function automatic logic [CNT_W-1:0] op_len(input sfot_op_type op);
      logic [CNT_W-1:0] v;
      v = '0;
      unique case (op)
         SFOT_OP_SSE: v = CNT_W'(SMALL_SECTOR_ERASE_DURATION);
         SFOT_OP_SE: v = CNT_W'(SECTOR_ERASE_DURATION);
         SFOT_OP_CHE: v = CNT_W'(WHOLE_ARRAY_ERASE_DURATION);
         SFOT_OP_WRSR: v = CNT_W'(STATUS_WRITE_DURATION);
         SFOT_OP_PP: v = CNT_W'(PAGE_PROGRAM_DURATION);
         default: v = '0;
      endcase
      return v;
   endfunction : op_len

   // ==========================================================
   // timer
   // ==========================================================
   sfot_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .load_in(load),
      .abort_in(abort),
      .len_in(len),
      .running_out(tmr_run),
      .done_out(tmr_done)
   );

   // next state
   always_comb begin
      state_nxt = state_r;
      wel_nxt = wel_r;
      busy_nxt = busy_r;
      ready_nxt = ready_r;
      pd_nxt = pd_r;
      done_nxt = 1'b0;
      rej_nxt = 1'b0;
      load = 1'b0;
      abort = 1'b0;
      len = '0;
      unique case (state_r)
         SFOT_IDLE: begin
            if (pd_enter_in) begin
               state_nxt = SFOT_DPD;
               pd_nxt = 1'b1;
               ready_nxt = 1'b0;
            end else if (op_start_in) begin
               if (wel_r && op_code_in != SFOT_OP_NONE) begin
                  state_nxt = SFOT_BUSY;
                  busy_nxt = 1'b1;
                  ready_nxt = 1'b0;
                  load = 1'b1;
                  len = op_len(op_code_in);
               end else begin
                  rej_nxt = 1'b1;
               end
            end else if (wrdi_cmd_in) begin
               wel_nxt = 1'b0;
            end else if (wren_cmd_in) begin
               wel_nxt = 1'b1;
            end
         end
         SFOT_BUSY: begin
            if (op_start_in || wren_cmd_in || wrdi_cmd_in) rej_nxt = 1'b1;
            if (tmr_done) begin
               state_nxt = SFOT_IDLE;
               busy_nxt = 1'b0;
               ready_nxt = 1'b1;
               wel_nxt = 1'b0;
               done_nxt = 1'b1;
            end else if (suspend_cmd_in) begin
               abort = 1'b1;
               load = 1'b1;
               len = CNT_W'(SUSPEND_RECOVERY_DELAY);
               state_nxt = SFOT_SUSP_REC;
            end
         end
         SFOT_SUSP_REC: begin
            if (tmr_done) begin
               state_nxt = SFOT_SUSPENDED;
               ready_nxt = 1'b1;
            end
         end
         SFOT_SUSPENDED: begin
            // suspended operation is dropped; latch is cleared here
            state_nxt = SFOT_IDLE;
            busy_nxt = 1'b0;
            wel_nxt = 1'b0;
         end
         SFOT_DPD: begin
            if (pd_exit_in) begin
               state_nxt = SFOT_DPD_REC;
               load = 1'b1;
               len = CNT_W'(POWERDOWN_EXIT_DELAY);
            end
         end
         SFOT_DPD_REC: begin
            if (tmr_done) begin
               state_nxt = SFOT_IDLE;
               pd_nxt = 1'b0;
               ready_nxt = 1'b1;
            end
         end
      endcase
   end

   // registers
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_r <= SFOT_IDLE;
         wel_r <= 1'b0;
         busy_r <= 1'b0;
         ready_r <= 1'b1;
         pd_r <= 1'b0;
         done_r <= 1'b0;
         rej_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wel_r <= wel_nxt;
         busy_r <= busy_nxt;
         ready_r <= ready_nxt;
         pd_r <= pd_nxt;
         done_r <= done_nxt;
         rej_r <= rej_nxt;
      end
   end

   // status outputs straight from flops
   assign busy_out = busy_r;
   assign wel_out = wel_r;
   assign ready_out = ready_r;
   assign powered_down_out = pd_r;
   assign op_done_out = done_r;
   assign rejected_out = rej_r;
endmodule : sfot_seq

// ### rtl/sfot_defines.svh
/*
 Timing figures and cycle counts of the internal operation sequencer.
 Assumes a 125 MHz core clock; counts other than page program are derived from the printed times.
*/
`ifndef SFOT_DEFINES_SVH
`define SFOT_DEFINES_SVH

// ==========================================================
// clock
// ==========================================================
`define SFOT_CLK_MHZ 125
// ==========================================================
// durations in ms (typical, maximum)
// ==========================================================
`define SFOT_SSE_TYP_MS 10
`define SFOT_SSE_MAX_MS 130
`define SFOT_SE_TYP_MS 15
`define SFOT_SE_MAX_MS 180
`define SFOT_CHE_TYP_MS 120
`define SFOT_CHE_MAX_MS 1500
`define SFOT_WRSR_TYP_MS 5
`define SFOT_WRSR_MAX_MS 8
// ==========================================================
// recovery delays in us (maximum)
// ==========================================================
`define SFOT_RSUS_MAX_US 40
`define SFOT_RDP_MAX_US 40
// ==========================================================
// derived cycle counts (typical figures used as busy time)
// ==========================================================
`define SFOT_MS_CYC (`SFOT_CLK_MHZ * 1000)
`define SFOT_SSE_CYC (`SFOT_SSE_TYP_MS * `SFOT_MS_CYC)
`define SFOT_SE_CYC (`SFOT_SE_TYP_MS * `SFOT_MS_CYC)
`define SFOT_CHE_CYC (`SFOT_CHE_TYP_MS * `SFOT_MS_CYC)
`define SFOT_WRSR_CYC (`SFOT_WRSR_TYP_MS * `SFOT_MS_CYC)
`define SFOT_RSUS_CYC (`SFOT_RSUS_MAX_US * `SFOT_CLK_MHZ)
`define SFOT_RDP_CYC (`SFOT_RDP_MAX_US * `SFOT_CLK_MHZ)
`define SFOT_PP_CYC 62500
`define SFOT_CNT_W 28

`endif

// ### rtl/sfot_pkg.sv
/*
 Types shared by the operation sequencer.
 Assumes sfot_defines.svh is available for widths.
*/
`include "sfot_defines.svh"

package sfot_pkg;
   // ==========================================================
   // operation codes
   // ==========================================================
   typedef enum logic [2:0] {
      SFOT_OP_NONE,
      SFOT_OP_SSE,
      SFOT_OP_SE,
      SFOT_OP_CHE,
      SFOT_OP_PP,
      SFOT_OP_WRSR
   } sfot_op_type;
   typedef logic [`SFOT_CNT_W-1:0] sfot_cnt_type;
endpackage : sfot_pkg

// ### rtl/sfot_timer.sv
/*
 Down counter: loaded with a length, pulses done when it reaches zero.
 Assumes load is a single-cycle request from the sequencer on the same clock.
*/
`timescale 1ns/100ps
`include "sfot_defines.svh"

module sfot_timer #(
   parameter int CNT_W = `SFOT_CNT_W
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // control
   input wire logic load_in,
   input wire logic abort_in,
   input wire logic [CNT_W-1:0] len_in,
   // status
   output logic running_out,
   output logic done_out
);
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic run_r, run_nxt;
   logic done_r, done_nxt;

   initial begin
      if (CNT_W < 2) $error("timer width too small");
   end

   // next count
   always_comb begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      done_nxt = 1'b0;
      // a reload wins over a stop in the same cycle, else suspend never recovers
      if (load_in) begin
         cnt_nxt = (len_in > 1) ? len_in - 1'b1 : '0;
         run_nxt = 1'b1;
      end else if (abort_in) begin
         run_nxt = 1'b0;
      end else if (run_r) begin
         if (cnt_r == '0) begin
            run_nxt = 1'b0;
            done_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 1'b1;
         end
      end
   end

   // registers
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         done_r <= done_nxt;
      end
   end

   assign running_out = run_r;
   assign done_out = done_r;
endmodule : sfot_timer

// ### bench/sfot_seq_checker.sv
/*
 Port checker of the operation sequencer, bound to sfot_seq.
 Assumes short durations from the bench and recovery delays of 10 cycles.
*/
`timescale 1ns/100ps

module sfot_seq_checker
   import sfot_pkg::*;
#(
   parameter int SMALL_SECTOR_ERASE_DURATION = 20,
   parameter int SECTOR_ERASE_DURATION = 24,
   parameter int WHOLE_ARRAY_ERASE_DURATION = 30,
   parameter int STATUS_WRITE_DURATION = 16,
   parameter int PAGE_PROGRAM_DURATION = 12
) (
   // clock, reset and commands
   input wire logic core_clk_in, sys_rst_in, wren_cmd_in, wrdi_cmd_in, op_start_in,
   input wire sfot_pkg::sfot_op_type op_code_in,
   input wire logic suspend_cmd_in, pd_enter_in, pd_exit_in,
   // status
   input wire logic busy_out, wel_out, ready_out, powered_down_out, op_done_out, rejected_out
);
   localparam int REC_MAX = 14;
   int len_r, len_nxt, cnt_r, cnt_nxt;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   // ==========================================================
   // busy length of the accepted operation
   // ==========================================================
   always_comb begin
      len_nxt = len_r;
      cnt_nxt = busy_out ? cnt_r + 1 : 0;
      if (op_start_in && !busy_out) begin
         case (op_code_in)
            SFOT_OP_SSE: len_nxt = SMALL_SECTOR_ERASE_DURATION;
            SFOT_OP_SE: len_nxt = SECTOR_ERASE_DURATION;
            SFOT_OP_CHE: len_nxt = WHOLE_ARRAY_ERASE_DURATION;
            SFOT_OP_PP: len_nxt = PAGE_PROGRAM_DURATION;
            SFOT_OP_WRSR: len_nxt = STATUS_WRITE_DURATION;
            default: len_nxt = 0;
         endcase
      end
   end
   always_ff @(posedge core_clk_in) begin
      len_r <= sys_rst_in ? 0 : len_nxt;
      cnt_r <= sys_rst_in ? 0 : cnt_nxt;
   end
   // ==========================================================
   // properties
   // ==========================================================
   property p_len; op_done_out |-> cnt_r == len_r + 1; endproperty
   a_len: assert property (p_len) else $error("busy length wrong");
   property p_wel; op_done_out |-> !wel_out; endproperty
   a_wel: assert property (p_wel) else $error("latch kept at end");
   property p_fall; $fell(busy_out) |-> !wel_out && ready_out; endproperty
   a_fall: assert property (p_fall) else $error("idle with latch set");
   property p_start;
      op_start_in && wel_out && ready_out && !busy_out && !powered_down_out && !pd_enter_in
         && op_code_in != SFOT_OP_NONE |=> busy_out && !ready_out;
   endproperty
   a_start: assert property (p_start) else $error("busy not raised");
   property p_rej;
      op_start_in && ready_out && !busy_out && !powered_down_out && !pd_enter_in
         && (!wel_out || op_code_in == SFOT_OP_NONE) |=> rejected_out && !busy_out;
   endproperty
   a_rej: assert property (p_rej) else $error("start not refused");
   property p_hold; $rose(busy_out) |-> busy_out [*8]; endproperty
   a_hold: assert property (p_hold) else $error("busy too short");
   property p_sus; suspend_cmd_in && busy_out && !ready_out |-> ##[1:REC_MAX] ready_out; endproperty
   a_sus: assert property (p_sus) else $error("suspend recovery late");
   property p_pdx;
      pd_exit_in && powered_down_out |-> ##[1:REC_MAX] (ready_out && !powered_down_out);
   endproperty
   a_pdx: assert property (p_pdx) else $error("power-down exit late");
endmodule : sfot_seq_checker

bind sfot_seq sfot_seq_checker #(
   .SMALL_SECTOR_ERASE_DURATION(SMALL_SECTOR_ERASE_DURATION),
   .SECTOR_ERASE_DURATION(SECTOR_ERASE_DURATION),
   .WHOLE_ARRAY_ERASE_DURATION(WHOLE_ARRAY_ERASE_DURATION),
   .STATUS_WRITE_DURATION(STATUS_WRITE_DURATION),
   .PAGE_PROGRAM_DURATION(PAGE_PROGRAM_DURATION)
) u_chk (.*);

// ### bench/sfot_host_model.sv
/*
 Host side model: issues one-cycle commands and polls busy.
 Assumes the sequencer samples its strobes on the rising edge.
*/
`timescale 1ns/100ps

module sfot_host_model
   import sfot_pkg::*;
(
   // clock and status seen
   input wire logic core_clk_in,
   input wire logic busy_in,
   // commands driven
   output logic wren_out, wrdi_out, start_out, sus_out, pde_out, pdx_out,
   output sfot_op_type code_out
);
   initial begin
      {wren_out, wrdi_out, start_out, sus_out, pde_out, pdx_out} = 6'h00;
      code_out = SFOT_OP_NONE;
   end
   // one command pulse, bits wren wrdi start suspend pd_enter pd_exit
   task automatic send(input logic [5:0] k, input sfot_op_type c);
      @(posedge core_clk_in);
      {wren_out, wrdi_out, start_out, sus_out, pde_out, pdx_out} <= k;
      code_out <= c;
      @(posedge core_clk_in);
      {wren_out, wrdi_out, start_out, sus_out, pde_out, pdx_out} <= 6'h00;
      code_out <= SFOT_OP_NONE;
   endtask : send
   // count busy samples until it clears, bounded
   task automatic wait_idle(output int n);
      int k;
      n = 0;
      for (k = 0; k < 5000; k++) begin
         @(posedge core_clk_in);
         if (busy_in) n++;
         else if (n > 0) break;
      end
   endtask : wait_idle
   // every modifying command gets a fresh enable first
   task automatic run_op(input sfot_op_type c, output int n);
      send(6'h20, SFOT_OP_NONE);
      send(6'h08, c);
      wait_idle(n);
   endtask : run_op
endmodule : sfot_host_model

// ### bench/test_serial_flash_op_timing.sv
/*
 Self-checking bench of the operation sequencer with short durations.
 Assumes the host model drives every command input.
*/
`timescale 1ns/100ps

module test_serial_flash_op_timing;
   import sfot_pkg::*;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic wren, wrdi, start, sus, pde, pdx, busy, wel, ready, pdn, done, rej;
   sfot_op_type code;
   int fail_count = 0;
   int checks = 0;
   // shortened busy and recovery lengths in cycles
   localparam int SMALL_LEN = 20;
   localparam int SECTOR_LEN = 24;
   localparam int CHIP_LEN = 30;
   localparam int STATUS_LEN = 16;
   localparam int PROG_LEN = 12;
   localparam int SUSP_LEN = 10;
   localparam int WAKE_LEN = 10;
   always #4 core_clk_in = ~core_clk_in;
   // ==========================================================
   // design and host
   // ==========================================================
   sfot_seq #(.SMALL_SECTOR_ERASE_DURATION(SMALL_LEN), .SECTOR_ERASE_DURATION(SECTOR_LEN),
      .WHOLE_ARRAY_ERASE_DURATION(CHIP_LEN), .STATUS_WRITE_DURATION(STATUS_LEN),
      .PAGE_PROGRAM_DURATION(PROG_LEN), .SUSPEND_RECOVERY_DELAY(SUSP_LEN),
      .POWERDOWN_EXIT_DELAY(WAKE_LEN)) DUT (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .wren_cmd_in(wren), .wrdi_cmd_in(wrdi), .op_start_in(start), .op_code_in(code),
      .suspend_cmd_in(sus), .pd_enter_in(pde), .pd_exit_in(pdx), .busy_out(busy),
      .wel_out(wel), .ready_out(ready), .powered_down_out(pdn), .op_done_out(done),
      .rejected_out(rej));
   sfot_host_model host (.core_clk_in(core_clk_in), .busy_in(busy), .wren_out(wren),
      .wrdi_out(wrdi), .start_out(start), .sus_out(sus), .pde_out(pde), .pdx_out(pdx),
      .code_out(code));
   // compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("Error %s expected %0h seen %0h", what, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic end_of_test();
      if (fail_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_ops();
      sfot_op_type c [5] = '{SFOT_OP_SSE, SFOT_OP_SE, SFOT_OP_CHE, SFOT_OP_PP, SFOT_OP_WRSR};
      int d [5] = '{SMALL_LEN, SECTOR_LEN, CHIP_LEN, PROG_LEN, STATUS_LEN};
      int n;
      for (int i = 0; i < 5; i++) begin
         host.run_op(c[i], n);
         chk("busy cycles", d[i] + 1, n);
         chk("latch after op", 1'b0, wel);
      end
   endtask : t_ops
   // start refused without a fresh enable or with no code
   task automatic t_reject();
      host.send(6'h08, SFOT_OP_SSE);
      #1;
      chk("refused, latch clear", 1'b1, rej);
      host.send(6'h20, SFOT_OP_NONE);
      host.send(6'h08, SFOT_OP_NONE);
      #1;
      chk("refused, no code", 1'b1, rej);
      host.send(6'h10, SFOT_OP_NONE);
      #1;
      chk("latch after disable", 1'b0, wel);
      host.send(6'h08, SFOT_OP_PP);
      #1;
      chk("refused after disable", 1'b1, rej);
      chk("not busy", 1'b0, busy);
   endtask : t_reject
   // suspend mid erase, busy clears within the recovery delay plus four cycles
   task automatic t_suspend();
      int n;
      host.send(6'h20, SFOT_OP_NONE);
      host.send(6'h08, SFOT_OP_SE);
      host.send(6'h20, SFOT_OP_NONE);
      #1;
      chk("enable refused in busy", 1'b1, rej);
      repeat (5) @(posedge core_clk_in);
      host.send(6'h04, SFOT_OP_NONE);
      host.wait_idle(n);
      chk("suspend recovery", 1'b1, n <= SUSP_LEN + 4);
      chk("latch after suspend", 1'b0, wel);
   endtask : t_suspend
   // deep power-down and exit
   task automatic t_pd();
      int n;
      host.send(6'h02, SFOT_OP_NONE);
      @(posedge core_clk_in); #1;
      chk("powered down", 1'b1, pdn);
      host.send(6'h01, SFOT_OP_NONE);
      for (n = 0; n < 50 && pdn; n++) @(posedge core_clk_in);
      chk("exit delay", 1'b1, n >= WAKE_LEN && n <= WAKE_LEN + 4);
      chk("ready after exit", 1'b1, ready);
   endtask : t_pd
   // watchdog
   initial begin
      repeat (5000) @(posedge core_clk_in);
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (3) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      t_ops();
      t_reject();
      t_suspend();
      t_pd();
      end_of_test();
   end
endmodule : test_serial_flash_op_timing
